// >>> verilog/ladder_scan_core.sv
// Cyclic ladder rung evaluation core with master clear
`timescale 1ns/1ps
`default_nettype none
`include "ladder_defines.svh"
module ladder_scan_core
  import ladder_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [`IN_COUNT-1:0]   input_terminals,
  input  wire logic                   prog_we,
  input  wire logic [`RUNG_AW-1:0]    prog_addr,
  input  wire logic [`RUNG_W-1:0]     prog_data,
  output logic [`OUT_COUNT-1:0]       local_relay_outputs,
  output logic [`OUT_COUNT-1:0]       expansion_outputs,
  output logic [`MARK_COUNT-1:0]      first_marker_bank,
  output logic [`MARK_COUNT-1:0]      second_marker_bank,
  output logic [`CLR_COUNT-1:0]       clear_contacts,
  output logic                        scan_done
);

  // ----------------------------------------------------------------
  // Program store and scan state
  // ----------------------------------------------------------------
  logic [`RUNG_W-1:0]  program_store [0:`RUNG_COUNT-1];
  scan_state_t         state;
  logic [`RUNG_AW-1:0] rung;
  logic [`IMG_W-1:0]   image;
  logic                acc;
  logic [`RUNG_W-1:0]  word;
  logic                conducts;
  logic                result;
  logic [5:0]          target;
  coil_fn_t            coil_fn;
  logic                parallel;
  logic [`IMG_W-1:0]   clear_mask;
  logic [`IMG_W-1:0]   cleared_image;

  // Program may be rewritten at any time; a rung changed mid-scan
  // takes effect from the point the scan reaches it.
  always_ff @(posedge clk) begin
    if (prog_we) begin
      program_store[prog_addr] <= prog_data;
    end
  end

  always_comb begin
    word     = program_store[rung];
    target   = word[`COIL_TGT_LSB +: 6];
    coil_fn  = coil_fn_t'(word[`COIL_FN_LSB +: 2]);
    parallel = word[`COIL_PAR_BIT];
  end

  contact_chain u_chain (
    .image    (image),
    .contacts (word[`CT_FIELD_W-1:0]),
    .conducts (conducts)
  );

  clear_mask_gen u_clear (
    .clear_coils (image[`IDX_Z +: `CLR_COUNT]),
    .mask        (clear_mask)
  );

  // parallel rungs OR with the accumulated branches
  always_comb begin
    result = acc | conducts;
  end

  // One cleared word feeds both image and pins, so they agree after every commit
  always_comb begin
    cleared_image = image & ~clear_mask;
  end

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  // one rung per clock, top to bottom
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= SCAN_LATCH;
      rung  <= `FIRST_RUNG;
    end else begin
      unique case (state)
        SCAN_LATCH: begin
          state <= SCAN_RUN;
          rung  <= `FIRST_RUNG;
        end
        SCAN_RUN: begin
          if (rung == `LAST_RUNG) begin
            state <= SCAN_COMMIT;
          end
          rung <= rung + 5'h01;
        end
        SCAN_COMMIT: begin
          state <= SCAN_LATCH;
        end
        // Unused state code falls back to a fresh scan
        default: begin
          state <= SCAN_LATCH;
        end
      endcase
    end
  end

  // branch accumulator spans any number of rungs marked parallel
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc <= 1'b0;
    end else if (state != SCAN_RUN) begin
      acc <= 1'b0;
    end else begin
      acc <= parallel ? result : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Operand image
  // ----------------------------------------------------------------
  // Coils write straight into the image, so later rungs of the same
  // scan already see them while earlier rungs only see them next scan.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      image <= `IMG_RESET;
    end else begin
      unique case (state)
        SCAN_LATCH: begin
          image[`IDX_IN +: `IN_COUNT] <= input_terminals;
          image[`IDX_ONE]             <= 1'b1;
        end
        SCAN_RUN: begin
          // coil result goes live in the image once driven
          if (!parallel && target != `IDX_ONE) begin
            unique case (coil_fn)
              COIL_NORMAL:  image[target] <= result;
              COIL_NEGATED: image[target] <= !result;
              COIL_SET: begin
                if (result) begin
                  image[target] <= 1'b1;
                end
              end
              // reset written later wins over an earlier set
              COIL_RESET: begin
                if (result) begin
                  image[target] <= 1'b0;
                end
              end
            endcase
          end
        end
        SCAN_COMMIT: begin
          // clear applied once per scan at commit, repeated each scan while coil stays high
          image <= cleared_image;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output pins, refreshed once per scan
  // ----------------------------------------------------------------
  // Pins only change after the clear has been merged, so a cleared
  // output never glitches high for a scan.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      local_relay_outputs <= '0;
      expansion_outputs   <= '0;
      first_marker_bank   <= '0;
      second_marker_bank  <= '0;
      clear_contacts      <= '0;
    end else if (state == SCAN_COMMIT) begin
      local_relay_outputs <= cleared_image[`IDX_Q +: `OUT_COUNT];
      expansion_outputs   <= cleared_image[`IDX_S +: `OUT_COUNT];
      first_marker_bank   <= cleared_image[`IDX_M +: `MARK_COUNT];
      second_marker_bank  <= cleared_image[`IDX_N +: `MARK_COUNT];
      // clear contacts follow their own coils
      clear_contacts      <= image[`IDX_Z +: `CLR_COUNT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_done <= 1'b0;
    end else begin
      scan_done <= (state == SCAN_COMMIT);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_clear_outputs;
    @(posedge clk) disable iff (reset)
      (state == SCAN_COMMIT && image[`IDX_Z]) |=> (local_relay_outputs == '0 && expansion_outputs == '0);
  endproperty
  a_clear_outputs: assert property (p_clear_outputs) else $error("output clear left an output set");

  property p_clear_markers;
    @(posedge clk) disable iff (reset)
      (state == SCAN_COMMIT && image[`IDX_Z + 6'h01]) |=> (first_marker_bank == '0 && second_marker_bank == '0);
  endproperty
  a_clear_markers: assert property (p_clear_markers) else $error("marker clear left a marker set");

  property p_clear_markers_only;
    @(posedge clk) disable iff (reset)
      (state == SCAN_COMMIT && image[`IDX_Z +: `CLR_COUNT] == 3'h2)
        |=> (local_relay_outputs == $past(image[`IDX_Q +: `OUT_COUNT]));
  endproperty
  a_clear_markers_only: assert property (p_clear_markers_only) else $error("marker clear touched outputs");

  property p_clear_all;
    @(posedge clk) disable iff (reset)
      (state == SCAN_COMMIT && image[`IDX_Z + 6'h02])
        |=> (local_relay_outputs == '0 && expansion_outputs == '0 &&
             first_marker_bank == '0 && second_marker_bank == '0);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("combined clear left a target set");

  property p_clear_held;
    @(posedge clk) disable iff (reset)
      clear_contacts[0] |-> (local_relay_outputs == '0);
  endproperty
  a_clear_held: assert property (p_clear_held) else $error("outputs set while clear held");

  property p_contact_follows;
    @(posedge clk) disable iff (reset)
      (state == SCAN_COMMIT) |=> (clear_contacts == $past(image[`IDX_Z +: `CLR_COUNT]));
  endproperty
  a_contact_follows: assert property (p_contact_follows) else $error("clear contact differs from coil");

  property p_normal_coil;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && !parallel && coil_fn == COIL_NORMAL && target != `IDX_ONE)
        |=> (image[$past(target)] == $past(result));
  endproperty
  a_normal_coil: assert property (p_normal_coil) else $error("coil did not store rung result");

  property p_negated_coil;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && !parallel && coil_fn == COIL_NEGATED && target != `IDX_ONE)
        |=> (image[$past(target)] == !$past(result));
  endproperty
  a_negated_coil: assert property (p_negated_coil) else $error("negated coil stored wrong level");

  property p_parallel_or;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && parallel && conducts) |=> acc;
  endproperty
  a_parallel_or: assert property (p_parallel_or) else $error("parallel branch lost");

  property p_top_down;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && rung != `LAST_RUNG) |=> (state == SCAN_RUN && rung == $past(rung) + 5'h01);
  endproperty
  a_top_down: assert property (p_top_down) else $error("rung order broken");

  property p_scan_bounded;
    @(posedge clk) disable iff (reset)
      (state == SCAN_LATCH) |-> ##[1:40] scan_done;
  endproperty
  a_scan_bounded: assert property (p_scan_bounded) else $error("scan did not complete");

  // Output clear must leave both marker banks alone
  property p_clear_outputs_only;
    @(posedge clk) disable iff (reset)
      (state == SCAN_COMMIT && image[`IDX_Z +: `CLR_COUNT] == 3'h1)
        |=> (first_marker_bank == $past(image[`IDX_M +: `MARK_COUNT]) &&
             second_marker_bank == $past(image[`IDX_N +: `MARK_COUNT]));
  endproperty
  a_clear_outputs_only: assert property (p_clear_outputs_only) else $error("output clear hit markers");

  // Retained coils keep the cleared level into the next scan
  property p_out_cleared;
    @(posedge clk) disable iff (reset)
      (state == SCAN_COMMIT && (image[`IDX_Z] || image[`IDX_Z + 6'h02]))
        |=> (image[`IDX_Q +: `OUT_COUNT] == '0 && image[`IDX_S +: `OUT_COUNT] == '0);
  endproperty
  a_out_cleared: assert property (p_out_cleared) else $error("output revived after clear");

  property p_mark_cleared;
    @(posedge clk) disable iff (reset)
      (state == SCAN_COMMIT && (image[`IDX_Z + 6'h01] || image[`IDX_Z + 6'h02]))
        |=> (image[`IDX_M +: `MARK_COUNT] == '0 && image[`IDX_N +: `MARK_COUNT] == '0);
  endproperty
  a_mark_cleared: assert property (p_mark_cleared) else $error("marker revived after clear");

  property p_set_coil;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && !parallel && coil_fn == COIL_SET && result && target != `IDX_ONE)
        |=> image[$past(target)];
  endproperty
  a_set_coil: assert property (p_set_coil) else $error("set coil did not store 1");

  property p_reset_coil;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && !parallel && coil_fn == COIL_RESET && result && target != `IDX_ONE)
        |=> !image[$past(target)];
  endproperty
  a_reset_coil: assert property (p_reset_coil) else $error("reset coil did not store 0");

  property p_retained_hold;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && !parallel && (coil_fn == COIL_SET || coil_fn == COIL_RESET) && !result)
        |=> (image[$past(target)] == $past(image[target]));
  endproperty
  a_retained_hold: assert property (p_retained_hold) else $error("idle retained coil changed");

  property p_parallel_no_write;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && parallel) |=> (image[$past(target)] == $past(image[target]));
  endproperty
  a_parallel_no_write: assert property (p_parallel_no_write) else $error("parallel rung wrote a coil");

  property p_branch_drop;
    @(posedge clk) disable iff (reset)
      (state == SCAN_RUN && !parallel) |=> !acc;
  endproperty
  a_branch_drop: assert property (p_branch_drop) else $error("branch carried past its coil");

  property p_inputs_latched;
    @(posedge clk) disable iff (reset)
      (state == SCAN_LATCH) |=> (image[`IDX_IN +: `IN_COUNT] == $past(input_terminals));
  endproperty
  a_inputs_latched: assert property (p_inputs_latched) else $error("inputs not latched at scan start");

  // Pins may only move at the end of a scan
  property p_pins_stand;
    @(posedge clk) disable iff (reset)
      (state != SCAN_COMMIT)
        |=> ($stable(local_relay_outputs) && $stable(expansion_outputs) &&
             $stable(first_marker_bank) && $stable(second_marker_bank));
  endproperty
  a_pins_stand: assert property (p_pins_stand) else $error("pins moved inside a scan");

  property p_done_pulse;
    @(posedge clk) disable iff (reset)
      scan_done |=> !scan_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("scan end pulse too long");

  c_output_clear: cover property (@(posedge clk) disable iff (reset) clear_contacts[0]);
  c_marker_clear: cover property (@(posedge clk) disable iff (reset) clear_contacts[1]);
  c_parallel:     cover property (@(posedge clk) disable iff (reset) state == SCAN_RUN && parallel && conducts);
  c_outputs_on:   cover property (@(posedge clk) disable iff (reset) local_relay_outputs != '0);
  c_all_clear:    cover property (@(posedge clk) disable iff (reset) clear_contacts[2]);

endmodule
`default_nettype wire

// >>> verilog/ladder_defines.svh
// Constants for the ladder rung evaluation core: operand map, rung word layout, clear masks
// Function
// - Output clear coil zeroes only the eight local and eight expansion outputs.
// - Marker clear coil zeroes only both sixteen-entry marker banks.
// - Combined clear coil zeroes all outputs and both marker banks together.
// - Clear acts on the rising result and for as long as it stays high.
// - Clear beats every other coil write, wherever the clear coil sits.
// - Each clear contact reads back its own clear coil state.
// - Make contact passes the operand value, break contact passes its inverse.
// - Coil stores 1 when energized, 0 otherwise; pins show stored states.
// - Negated contact delivers the inverse of its operand.
// - Negated coil stores the inverse of its rung result.
// - A rung holds at most three series contacts.
// - Series contacts combine by AND; break contacts in series give NOR.
// - Parallel rungs onto one coil combine by OR; break contacts give NAND.
// - Parallel count is bounded only by the rungs in the program store.
// - Crossed make/break pairs in parallel energize on exactly one input active.
// - Own contact parallel to start holds the coil until stop breaks the rung.
// - Rungs are evaluated and coils driven strictly top to bottom each scan.
// - Coil results reach contacts once driven; earlier rungs see them next scan.
`ifndef LADDER_DEFINES_SVH
`define LADDER_DEFINES_SVH

// ----------------------------------------------------------------
// Operand image map (6-bit contact and coil index)
// ----------------------------------------------------------------
`define IMG_W         64
`define IN_COUNT      8
`define IDX_IN        6'h00
`define IDX_Q         6'h08
`define IDX_S         6'h10
`define IDX_M         6'h18
`define IDX_N         6'h28
`define IDX_Z         6'h38
`define IDX_ONE       6'h3f
`define OUT_COUNT     8
`define MARK_COUNT    16
`define CLR_COUNT     3
`define IMG_RESET     64'h0000_0000_0000_0000

// ----------------------------------------------------------------
// Rung word layout
// ----------------------------------------------------------------
`define RUNG_W        33
`define CT_W          8
`define CT_SEL_LSB    0
`define CT_NEG_BIT    6
`define CT_USED_BIT   7
`define CT_FIELD_W    24
`define COIL_TGT_LSB  24
`define COIL_FN_LSB   30
`define COIL_PAR_BIT  32
`define RUNG_COUNT    32
`define RUNG_AW       5
`define LAST_RUNG     5'h1f
`define FIRST_RUNG    5'h00

// ----------------------------------------------------------------
// Clear target masks over the image
// ----------------------------------------------------------------
`define MASK_OUTPUTS  64'h0000_0000_00ff_ff00
`define MASK_MARKERS  64'h00ff_ffff_ff00_0000
`define MASK_NONE     64'h0000_0000_0000_0000

`endif

// >>> verilog/ladder_pkg.sv
// Types shared by the ladder rung evaluation core
`default_nettype none
package ladder_pkg;

  typedef enum logic [1:0] {
    COIL_NORMAL,
    COIL_NEGATED,
    COIL_SET,
    COIL_RESET
  } coil_fn_t;

  typedef enum logic [1:0] {
    SCAN_LATCH,
    SCAN_RUN,
    SCAN_COMMIT
  } scan_state_t;

endpackage
`default_nettype wire

// >>> verilog/contact_chain.sv
// Series evaluation of the three contact fields of one rung
`timescale 1ns/1ps
`default_nettype none
`include "ladder_defines.svh"
module contact_chain
  import ladder_pkg::*;
(
  input  wire logic [`IMG_W-1:0]      image,
  input  wire logic [`CT_FIELD_W-1:0] contacts,
  output logic                        conducts
);

  // One contact: unused field is a plain wire
  function automatic logic contact_pass(input logic [`IMG_W-1:0] img, input logic [`CT_W-1:0] ct);
    logic bit_val;
    bit_val = img[ct[`CT_SEL_LSB +: 6]];
    contact_pass = !ct[`CT_USED_BIT] || (bit_val ^ ct[`CT_NEG_BIT]);
  endfunction

  always_comb begin
    conducts = contact_pass(image, contacts[0 +: `CT_W]) &
               contact_pass(image, contacts[`CT_W +: `CT_W]) &
               contact_pass(image, contacts[2*`CT_W +: `CT_W]);
  end

endmodule
`default_nettype wire

// >>> verilog/clear_mask_gen.sv
// Target set of the three master clear coils
`timescale 1ns/1ps
`default_nettype none
`include "ladder_defines.svh"
module clear_mask_gen
  import ladder_pkg::*;
(
  input  wire logic [`CLR_COUNT-1:0] clear_coils,
  output logic [`IMG_W-1:0]          mask
);

  always_comb begin
    mask = `MASK_NONE;
    if (clear_coils[0]) begin
      mask = mask | `MASK_OUTPUTS;
    end
    if (clear_coils[1]) begin
      mask = mask | `MASK_MARKERS;
    end
    if (clear_coils[2]) begin
      mask = mask | `MASK_OUTPUTS | `MASK_MARKERS;
    end
  end

endmodule
`default_nettype wire

// >>> verification/ladder_scan_core_tb_top.sv
// Self-checking bench for the ladder rung evaluation core
`timescale 1ns/1ps
`default_nettype none
`include "ladder_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module ladder_scan_core_tb_top
  import ladder_pkg::*;
;
  logic                    clk;
  logic                    reset;
  logic [`IN_COUNT-1:0]    input_terminals;
  logic                    prog_we;
  logic [`RUNG_AW-1:0]     prog_addr;
  logic [`RUNG_W-1:0]      prog_data;
  logic [`OUT_COUNT-1:0]   local_relay_outputs;
  logic [`OUT_COUNT-1:0]   expansion_outputs;
  logic [`MARK_COUNT-1:0]  first_marker_bank;
  logic [`MARK_COUNT-1:0]  second_marker_bank;
  logic [`CLR_COUNT-1:0]   clear_contacts;
  logic                    scan_done;
  logic                    q6;
  logic                    q7;
  int                      miscompares = 0;
  int                      n_compared  = 0;
  int                      cycles      = 0;

  ladder_scan_core i_dut (
    .clk                 (clk),
    .reset               (reset),
    .input_terminals     (input_terminals),
    .prog_we             (prog_we),
    .prog_addr           (prog_addr),
    .prog_data           (prog_data),
    .local_relay_outputs (local_relay_outputs),
    .expansion_outputs   (expansion_outputs),
    .first_marker_bank   (first_marker_bank),
    .second_marker_bank  (second_marker_bank),
    .clear_contacts      (clear_contacts),
    .scan_done           (scan_done)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Thirty-three steps of about two scans each; the ceiling leaves a wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  function automatic logic [7:0] ct(input logic [5:0] s, input logic n);
    return {1'b1, n, s};
  endfunction

  function automatic logic [32:0] rw(input logic p, input coil_fn_t f, input logic [5:0] t,
                                     input logic [7:0] a, input logic [7:0] b, input logic [7:0] d);
    return {p, f, t, d, b, a};
  endfunction

  task automatic load_program();
    logic [`RUNG_W-1:0] p [`RUNG_COUNT];
    int                 k;
    for (k = 0; k < `RUNG_COUNT; k++) p[k] = rw(1'b0, COIL_NORMAL, `IDX_ONE, 8'h00, 8'h00, 8'h00);
    // Output clear at the top: its override must not depend on rung position
    p[0]  = rw(1'b0, COIL_NORMAL, `IDX_Z, ct(6'h07, 1'b0), ct(6'h02, 1'b0), ct(6'h03, 1'b1));
    p[1]  = rw(1'b0, COIL_NORMAL, `IDX_Q, ct(6'h02, 1'b0), ct(6'h03, 1'b0), ct(6'h04, 1'b0));
    p[2]  = rw(1'b0, COIL_NORMAL, `IDX_Q+6'h01, ct(6'h02, 1'b1), ct(6'h03, 1'b1), ct(6'h04, 1'b1));
    p[3]  = rw(1'b1, COIL_NORMAL, `IDX_ONE, ct(6'h02, 1'b0), 8'h00, 8'h00);
    p[4]  = rw(1'b1, COIL_NORMAL, `IDX_ONE, ct(6'h03, 1'b0), 8'h00, 8'h00);
    p[5]  = rw(1'b0, COIL_NORMAL, `IDX_Q+6'h02, ct(6'h04, 1'b0), 8'h00, 8'h00);
    p[6]  = rw(1'b1, COIL_NORMAL, `IDX_ONE, ct(6'h02, 1'b1), 8'h00, 8'h00);
    p[7]  = rw(1'b1, COIL_NORMAL, `IDX_ONE, ct(6'h03, 1'b1), 8'h00, 8'h00);
    p[8]  = rw(1'b0, COIL_NORMAL, `IDX_Q+6'h03, ct(6'h04, 1'b1), 8'h00, 8'h00);
    p[9]  = rw(1'b1, COIL_NORMAL, `IDX_ONE, ct(6'h02, 1'b0), ct(6'h03, 1'b1), 8'h00);
    p[10] = rw(1'b0, COIL_NORMAL, `IDX_Q+6'h04, ct(6'h02, 1'b1), ct(6'h03, 1'b0), 8'h00);
    p[11] = rw(1'b0, COIL_NEGATED, `IDX_Q+6'h05, ct(6'h02, 1'b0), 8'h00, 8'h00);
    p[12] = rw(1'b1, COIL_NORMAL, `IDX_ONE, ct(6'h00, 1'b0), ct(6'h01, 1'b0), 8'h00);
    p[13] = rw(1'b0, COIL_NORMAL, `IDX_Q+6'h06, ct(`IDX_Q+6'h06, 1'b0), ct(6'h01, 1'b0), 8'h00);
    p[14] = rw(1'b0, COIL_NORMAL, `IDX_S, ct(6'h05, 1'b0), 8'h00, 8'h00);
    p[15] = rw(1'b0, COIL_NORMAL, `IDX_M, ct(6'h05, 1'b0), 8'h00, 8'h00);
    p[16] = rw(1'b0, COIL_NORMAL, `IDX_N, ct(6'h05, 1'b0), 8'h00, 8'h00);
    p[17] = rw(1'b0, COIL_NORMAL, `IDX_N+6'h01, ct(`IDX_Z, 1'b0), 8'h00, 8'h00);
    p[18] = rw(1'b0, COIL_SET, `IDX_Q+6'h07, ct(6'h06, 1'b0), 8'h00, 8'h00);
    p[19] = rw(1'b0, COIL_RESET, `IDX_Q+6'h07, ct(6'h07, 1'b0), ct(6'h02, 1'b1), ct(6'h03, 1'b1));
    p[20] = rw(1'b0, COIL_NORMAL, `IDX_S+6'h01, ct(`IDX_ONE, 1'b0), 8'h00, 8'h00);
    p[30] = rw(1'b0, COIL_NORMAL, `IDX_Z+6'h01, ct(6'h07, 1'b0), ct(6'h02, 1'b1), ct(6'h03, 1'b0));
    p[31] = rw(1'b0, COIL_NORMAL, `IDX_Z+6'h02, ct(6'h07, 1'b0), ct(6'h02, 1'b0), ct(6'h03, 1'b0));
    for (k = 0; k < `RUNG_COUNT; k++) begin
      @(negedge clk);
      prog_we = 1'b1;
      prog_addr = k[4:0];
      prog_data = p[k];
    end
    @(negedge clk);
    prog_we = 1'b0;
  endtask

  // Two scan ends guarantee that one full scan latched the new inputs
  task automatic step(input logic [7:0] v);
    logic [7:0]  eq;
    logic [7:0]  es;
    logic [15:0] em;
    logic [15:0] en;
    logic [2:0]  z;
    int          seen;
    int          k;
    @(negedge clk);
    input_terminals = v;
    seen = 0;
    for (k = 0; k < 120 && seen < 2; k++) begin
      @(negedge clk);
      if (scan_done === 1'b1) seen++;
    end
    `CHK("scan_done count", 2, seen)
    z = {v[7] & v[2] & v[3], v[7] & ~v[2] & v[3], v[7] & v[2] & ~v[3]};
    eq = {q7, q6, ~v[2], v[2] ^ v[3], ~&v[4:2], |v[4:2], ~|v[4:2], &v[4:2]};
    es = {6'h00, 1'b1, v[5]};
    em = {15'h0000, v[5]};
    en = {14'h0000, z[0], v[5]};
    if (z[0] | z[2]) begin
      eq = 8'h00;
      es = 8'h00;
    end
    if (z[1] | z[2]) begin
      em = 16'h0000;
      en = 16'h0000;
    end
    `CHK("local_relay_outputs", eq, local_relay_outputs)
    `CHK("expansion_outputs", es, expansion_outputs)
    `CHK("first_marker_bank", em, first_marker_bank)
    `CHK("second_marker_bank", en, second_marker_bank)
    `CHK("clear_contacts", z, clear_contacts)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_logic();
    int k;
    for (k = 0; k < 8; k++) begin
      step({3'b000, k[2:0], 2'b10});
    end
  endtask

  task automatic t_latch();
    q6 = 1'b1;
    step(8'h03);
    step(8'h02);
    q6 = 1'b0;
    step(8'h00);
    step(8'h01);
    step(8'h02);
  endtask

  task automatic t_setreset();
    q7 = 1'b1;
    step(8'h42);
    step(8'h02);
    q7 = 1'b0;
    step(8'h82);
    step(8'hc2);
    step(8'h02);
  endtask

  // Set input stays high through the clear to show the override
  task automatic t_clear();
    logic [7:0] mode [3];
    int         k;
    mode = '{8'h04, 8'h08, 8'h0c};
    for (k = 0; k < 3; k++) begin
      q6 = 1'b1;
      q7 = 1'b1;
      step(8'h63);
      step(8'h22);
      step(8'he2 | mode[k]);
      step(8'he2 | mode[k]);
      if (k != 1) begin
        q6 = 1'b0;
        q7 = 1'b0;
      end
      step(8'h22);
    end
  endtask

  initial begin
    reset = 1'b1;
    input_terminals = 8'h02;
    prog_we = 1'b0;
    prog_addr = 5'h00;
    prog_data = 33'h0_0000_0000;
    q6 = 1'b0;
    q7 = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("reset local_relay_outputs", 8'h00, local_relay_outputs)
    `CHK("reset second_marker_bank", 16'h0000, second_marker_bank)
    `CHK("reset expansion_outputs", 8'h00, expansion_outputs)
    `CHK("reset first_marker_bank", 16'h0000, first_marker_bank)
    `CHK("reset clear_contacts", 3'h0, clear_contacts)
    `CHK("reset scan_done", 1'b0, scan_done)
    repeat (5) @(negedge clk);
    reset = 1'b0;
    load_program();
    t_logic();
    t_latch();
    t_setreset();
    t_clear();
    stop_test();
  end
endmodule
`default_nettype wire
